/* File: mpl_pkg.sv */
// Purpose: constants for the panel and line control block
// Assumes: 40 MHz system clock
// Notes: bit positions follow the command, status and error words
package mpl_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int WD_TIME_S = 30;
    localparam longint WD_CYCLES = longint'(WD_TIME_S) * CLK_HZ;
    localparam int DEB_TIME_US = 1000;
    localparam int DEB_CYCLES = (DEB_TIME_US * (CLK_HZ / 1_000_000));
    // options word bits
    localparam int OPT_PANEL_OFF = 4;
    localparam int OPT_HOOK_LATCH = 3;
    // command word bits
    localparam int CMD_MULTIDROP = 3;
    localparam int CMD_TRANSPARENT = 4;
    localparam int CMD_TALK = 6;
    localparam int CMD_WATCHDOG = 7;
    localparam int CMD_LEASED = 14;
    localparam int CMD_TWO_WIRE = 15;
    // status word bits
    localparam int ST_OFF_HOOK = 1;
    localparam int ST_TRANSPARENT = 4;
    localparam int ST_ORIGINATE = 5;
    localparam int ST_HOOK_INPUT = 15;
    // error word bit
    localparam int ERR_MULTIDROP = 3;
    // reset values
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] ERROR_RESET = 16'h0000;
endpackage

/* File: mpl_panel_line.sv */
// Purpose: front panel, hook input and line mode control
// Assumes: switch and hook inputs are asynchronous, active high
// Notes: switch positions act once on entry, not while held
// Function
// - options bit 4 disables all panel switches
// - mode toggle transparent sets status bit 4
// - mode toggle native clears status bit 4
// - originate position disables auto-answer, sets bit 5
// - answer position enables auto-answer, clears bit 5
// - connect goes off hook, sets bit 1
// - connect dials only with non-zero pointer
// - hang-up goes on hook, clears bit 1
// - hook input high: off hook, bit 15
// - hook input low: hang up, clear 15
// - continuation dialing ignores hook input
// - watchdog dials after 30 s without edge
// - options bit 3 latches hook assertion
// - talk relay closes on rts or bit 6
// - dial-up ignores multidrop, sets error bit 3
// - dial-up selection cancels active multidrop
// - bit 14 set, 15 clear: four-wire leased
// - leased point-to-point starts carrier at entry
// - leased originator restarts carrier on loss
// - two-wire leased holds line off hook
// - bits 14 and 15 set: two-wire leased
`timescale 1ns/1ps
`default_nettype none
module mpl_panel_line
    import mpl_pkg::*;
#(
    parameter longint WD_COUNT = WD_CYCLES,
    parameter int DEB_COUNT = DEB_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic sw_transparent,
    input wire logic sw_native,
    input wire logic sw_originate,
    input wire logic sw_answer,
    input wire logic sw_connect,
    input wire logic sw_hangup,
    input wire logic hook_input,
    input wire logic [15:0] options_word,
    input wire logic [15:0] command_word,
    input wire logic [15:0] dial_pointer,
    input wire logic dial_continue,
    input wire logic carrier_detect,
    input wire logic rts,
    output logic transparent_mode,
    output logic auto_answer,
    output logic answer_lamp,
    output logic off_hook,
    output logic off_hook_lamp,
    output logic phone_relay_open,
    output logic dial_start,
    output logic carrier_start,
    output logic talk_relay_output,
    output logic multidrop_active,
    output logic four_wire_leased,
    output logic two_wire_leased,
    output logic [15:0] status_word,
    output logic [15:0] error_word
);
    localparam int NIN = 7;
    localparam int DW = $clog2(DEB_COUNT + 1);
    localparam int WW = $clog2(WD_COUNT + 1);

    // refuse counts the debounce and watchdog cannot serve
    if (DEB_COUNT < 1 || WD_COUNT < 2) begin : g_bad_count
        $error("mpl_panel_line: counts too small");
    end

    typedef struct packed {
        logic [NIN-1:0] sync1;
        logic [NIN-1:0] sync2;
        logic [NIN-1:0] stable;
        logic [NIN-1:0][DW-1:0] deb;
        logic [WW-1:0] wd_cnt;
        logic hook_latched;
        logic panel_hook;
        logic was_leased;
        logic was_carrier;
        logic transparent_mode;
        logic auto_answer;
        logic off_hook;
        logic dial_start;
        logic carrier_start;
        logic talk;
        logic multidrop;
        logic four_wire;
        logic two_wire;
        logic [15:0] status;
        logic [15:0] error;
    } mpl_state_t;

    mpl_state_t q, next_q;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] rise;
    logic [NIN-1:0] fall;
    logic leased_any;

    assign raw = {hook_input, sw_hangup, sw_connect, sw_answer,
                  sw_originate, sw_native, sw_transparent};
    assign leased_any = command_word[CMD_LEASED];

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_deb
            assign rise[gi] = q.sync2[gi] && !q.stable[gi]
                && (q.deb[gi] == DW'(DEB_COUNT));
            assign fall[gi] = !q.sync2[gi] && q.stable[gi]
                && (q.deb[gi] == DW'(DEB_COUNT));
        end
    endgenerate

    always_comb begin
        logic panel_on;
        logic hook_level;
        logic go_dial;
        panel_on = 1'b0;
        hook_level = 1'b0;
        go_dial = 1'b0;
        next_q = q;
        next_q.sync1 = raw;
        next_q.sync2 = q.sync1;
        next_q.dial_start = 1'b0;
        next_q.carrier_start = 1'b0;
        for (int i = 0; i < NIN; i++) begin
            if (q.sync2[i] == q.stable[i]) begin
                next_q.deb[i] = '0;
            end else if (q.deb[i] == DW'(DEB_COUNT)) begin
                next_q.stable[i] = q.sync2[i];
                next_q.deb[i] = '0;
            end else begin
                next_q.deb[i] = q.deb[i] + DW'(1);
            end
        end
        panel_on = !options_word[OPT_PANEL_OFF];
        if (panel_on) begin
            if (rise[0]) begin
                next_q.transparent_mode = 1'b1;
            end else if (rise[1]) begin
                next_q.transparent_mode = 1'b0;
            end
            if (rise[2]) begin
                next_q.auto_answer = 1'b0;
            end else if (rise[3]) begin
                next_q.auto_answer = 1'b1;
            end
            if (rise[4]) begin
                next_q.panel_hook = 1'b1;
                go_dial = (dial_pointer != 16'h0000);
            end else if (rise[5]) begin
                next_q.panel_hook = 1'b0;
            end
        end
        if (rise[6] && options_word[OPT_HOOK_LATCH]) begin
            next_q.hook_latched = 1'b1;
        end else if (!options_word[OPT_HOOK_LATCH]) begin
            next_q.hook_latched = 1'b0;
        end
        if (rise[6] && dial_pointer != 16'h0000) begin
            go_dial = 1'b1;
        end
        hook_level = next_q.stable[6] || next_q.hook_latched;
        if (dial_continue && !carrier_detect && q.off_hook) begin
            hook_level = 1'b1;
        end
        if (!command_word[CMD_WATCHDOG] || rise[6] || fall[6]) begin
            next_q.wd_cnt = '0;
        end else if (q.wd_cnt == WW'(WD_COUNT - 1)) begin
            next_q.wd_cnt = '0;
            go_dial = 1'b1;
            next_q.panel_hook = 1'b1;
        end else begin
            next_q.wd_cnt = q.wd_cnt + WW'(1);
        end
        next_q.four_wire = command_word[CMD_LEASED]
            && !command_word[CMD_TWO_WIRE];
        next_q.two_wire = command_word[CMD_LEASED]
            && command_word[CMD_TWO_WIRE];
        if (!leased_any && command_word[CMD_MULTIDROP]) begin
            next_q.error[ERR_MULTIDROP] = 1'b1;
        end
        next_q.multidrop = next_q.two_wire
            && command_word[CMD_MULTIDROP]
            && command_word[CMD_TRANSPARENT];
        next_q.off_hook = next_q.panel_hook || hook_level || next_q.two_wire;
        if (rise[5] && panel_on && !hook_level && !next_q.two_wire) begin
            next_q.off_hook = 1'b0;
        end
        next_q.dial_start = go_dial && !leased_any;
        next_q.was_leased = leased_any;
        next_q.was_carrier = carrier_detect;
        if (leased_any && !next_q.multidrop && !q.was_leased) begin
            next_q.carrier_start = 1'b1;
        end
        if (leased_any && !next_q.multidrop && !q.auto_answer
                && q.was_carrier && !carrier_detect) begin
            next_q.carrier_start = 1'b1;
        end
        next_q.talk = rts || command_word[CMD_TALK];
        next_q.status[ST_TRANSPARENT] = next_q.transparent_mode;
        next_q.status[ST_ORIGINATE] = !next_q.auto_answer;
        next_q.status[ST_OFF_HOOK] = next_q.panel_hook;
        // bit 15 shows the input itself; latch and continuation only hold
        next_q.status[ST_HOOK_INPUT] = next_q.stable[6];
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
            q.status <= STATUS_RESET | (16'h0001 << ST_ORIGINATE);
            q.error <= ERROR_RESET;
        end else if (clk_en) begin
            q <= next_q;
        end
    end

    assign transparent_mode = q.transparent_mode;
    assign auto_answer = q.auto_answer;
    assign answer_lamp = q.auto_answer;
    assign off_hook = q.off_hook;
    assign off_hook_lamp = q.off_hook;
    assign phone_relay_open = q.off_hook;
    assign dial_start = q.dial_start;
    assign carrier_start = q.carrier_start;
    assign talk_relay_output = q.talk;
    assign multidrop_active = q.multidrop;
    assign four_wire_leased = q.four_wire;
    assign two_wire_leased = q.two_wire;
    assign status_word = q.status;
    assign error_word = q.error;

    property p_talk;
        @(posedge clk) disable iff (!reset_n)
        clk_en && (rts || command_word[CMD_TALK]) |=> talk_relay_output;
    endproperty
    a_talk: assert property (p_talk) else $error("talk relay open");

    property p_two_wire_hook;
        @(posedge clk) disable iff (!reset_n)
        two_wire_leased |-> off_hook;
    endproperty
    a_two_wire_hook: assert property (p_two_wire_hook)
        else $error("two-wire leased not off hook");

    property p_md_err;
        @(posedge clk) disable iff (!reset_n)
        clk_en && !command_word[CMD_LEASED] && command_word[CMD_MULTIDROP]
            |=> error_word[ERR_MULTIDROP] && !multidrop_active;
    endproperty
    a_md_err: assert property (p_md_err)
        else $error("multidrop in dial-up not flagged");

    property p_status_mode;
        @(posedge clk) disable iff (!reset_n)
        status_word[ST_TRANSPARENT] == transparent_mode
            && status_word[ST_ORIGINATE] == !auto_answer;
    endproperty
    a_status_mode: assert property (p_status_mode)
        else $error("status mode bits disagree");

    property p_lamp;
        @(posedge clk) disable iff (!reset_n)
        answer_lamp == auto_answer && off_hook_lamp == off_hook
            && phone_relay_open == off_hook;
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp mismatch");

    property p_no_dial_zero;
        @(posedge clk) disable iff (!reset_n)
        clk_en && rise[4] && !rise[6] && dial_pointer == 16'h0000
            && !(q.wd_cnt == WW'(WD_COUNT - 1)) |=> !dial_start;
    endproperty
    a_no_dial_zero: assert property (p_no_dial_zero)
        else $error("dialed with zero pointer");

    property p_four_wire;
        @(posedge clk) disable iff (!reset_n)
        clk_en |=> four_wire_leased == ($past(command_word[CMD_LEASED])
            && !$past(command_word[CMD_TWO_WIRE]));
    endproperty
    a_four_wire: assert property (p_four_wire)
        else $error("four-wire select wrong");

    property p_panel_off;
        @(posedge clk) disable iff (!reset_n)
        clk_en && options_word[OPT_PANEL_OFF]
            |=> $stable(transparent_mode) && $stable(auto_answer);
    endproperty
    a_panel_off: assert property (p_panel_off)
        else $error("panel acted while disabled");

    c_connect: cover property (@(posedge clk) disable iff (!reset_n)
        rise[4] ##1 off_hook);
    c_watchdog: cover property (@(posedge clk) disable iff (!reset_n)
        command_word[CMD_WATCHDOG] && dial_start);
    c_leased: cover property (@(posedge clk) disable iff (!reset_n)
        carrier_start);
endmodule
`default_nettype wire

/* File: mpl_operator.sv */
// Purpose: operator panel and hook-control equipment model
// Assumes: a press holds one switch position for ten cycles
// Notes: keep-alive toggles the hook input every ten cycles
`timescale 1ns/1ps
`default_nettype none
module mpl_operator (
    input wire logic clk,
    input wire logic press,
    input wire logic [2:0] sel,
    input wire logic hook_req,
    input wire logic keep_alive,
    output logic sw_transparent,
    output logic sw_native,
    output logic sw_originate,
    output logic sw_answer,
    output logic sw_connect,
    output logic sw_hangup,
    output logic hook_input
);
    logic [3:0] hold_cnt = 4'h0;
    logic [2:0] held = 3'h0;
    logic [3:0] ka_cnt = 4'h0;
    logic toggle = 1'b0;
    logic act;
    // spring return: released after the hold
    always_ff @(posedge clk) begin
        if (press) begin
            hold_cnt <= 4'ha;
            held <= sel;
        end else if (hold_cnt != 4'h0) begin
            hold_cnt <= hold_cnt - 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (!keep_alive) begin
            ka_cnt <= 4'h0;
            toggle <= 1'b0;
        end else if (ka_cnt == 4'h9) begin
            ka_cnt <= 4'h0;
            toggle <= ~toggle;
        end else begin
            ka_cnt <= ka_cnt + 4'h1;
        end
    end
    assign act = (hold_cnt != 4'h0);
    assign sw_transparent = act && (held == 3'h1);
    assign sw_native = act && (held == 3'h2);
    assign sw_originate = act && (held == 3'h3);
    assign sw_answer = act && (held == 3'h4);
    assign sw_connect = act && (held == 3'h5);
    assign sw_hangup = act && (held == 3'h6);
    assign hook_input = hook_req ^ toggle;
endmodule
`default_nettype wire

/* File: modem_panel_line_control_bench.sv */
// Purpose: self-checking bench for panel and line control
// Assumes: short debounce and watchdog counts
// Notes: status changes are matched against queued notes
`timescale 1ns/1ps
`default_nettype none
module modem_panel_line_control_bench;
    import mpl_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, press = 1'b0, hook_req = 1'b0;
    logic keep_alive = 1'b0, rts = 1'b0, carrier_detect = 1'b0;
    logic dial_continue = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [15:0] options_word = 16'h0000, command_word = 16'h0000;
    logic [15:0] dial_pointer = 16'h0000, prev = 16'h0020;
    logic sw_t, sw_n, sw_o, sw_a, sw_c, sw_h, hook_input;
    logic tm, aa, al, oh, ohl, pro, ds, cs, talk, md, fw, tw;
    logic [15:0] status_word, error_word;
    logic [19:0] q[$];
    int bad_count = 0, n_checks = 0, dials = 0, carriers = 0, snap, i;
    bit watch = 1'b1;
    int seed = 32'hd21a;
    initial forever #12.5 clk = ~clk;
    mpl_operator u_op (.clk(clk), .press(press), .sel(sel),
        .hook_req(hook_req), .keep_alive(keep_alive), .sw_transparent(sw_t),
        .sw_native(sw_n), .sw_originate(sw_o), .sw_answer(sw_a),
        .sw_connect(sw_c), .sw_hangup(sw_h), .hook_input(hook_input));
    mpl_panel_line #(.WD_COUNT(20), .DEB_COUNT(2)) u_dut (.clk(clk),
        .reset_n(reset_n), .clk_en(1'b1), .sw_transparent(sw_t),
        .sw_native(sw_n), .sw_originate(sw_o), .sw_answer(sw_a),
        .sw_connect(sw_c), .sw_hangup(sw_h), .hook_input(hook_input),
        .options_word(options_word), .command_word(command_word),
        .dial_pointer(dial_pointer), .dial_continue(dial_continue),
        .carrier_detect(carrier_detect), .rts(rts), .transparent_mode(tm),
        .auto_answer(aa), .answer_lamp(al), .off_hook(oh),
        .off_hook_lamp(ohl), .phone_relay_open(pro), .dial_start(ds),
        .carrier_start(cs), .talk_relay_output(talk),
        .multidrop_active(md), .four_wire_leased(fw),
        .two_wire_leased(tw), .status_word(status_word),
        .error_word(error_word));
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [19:0] ex(logic h, logic a, logic t,
        logic [15:0] s);
        return {h, h, a, t, s};
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic act(input logic [2:0] s);
        sel <= s;
        press <= 1'b1;
        @(posedge clk);
        press <= 1'b0;
        repeat (25) @(posedge clk);
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic do_reset();
        reset_n <= 1'b0;
        hold(12);
        reset_n <= 1'b1;
        hold(2);
    endtask
    // monitor: while watch is set, each status change consumes the oldest note
    always @(posedge clk) begin
        if (ds === 1'b1) dials++;
        if (cs === 1'b1) carriers++;
        if (reset_n && watch && status_word !== prev) begin
            if (q.size() == 0) chk(status_word, prev);
            else chk({ohl, pro, al, tm, status_word}, q.pop_front());
        end
        prev = status_word;
    end
    initial begin
        do_reset();
        q.push_back(ex(0, 0, 1, 16'h0030));
        act(1);
        q.push_back(ex(0, 0, 0, 16'h0020));
        act(2);
        q.push_back(ex(0, 1, 0, 16'h0000));
        act(4);
        q.push_back(ex(0, 0, 0, 16'h0020));
        act(3);
        q.push_back(ex(1, 0, 0, 16'h0022));
        act(5);
        chk(dials, 0);
        q.push_back(ex(0, 0, 0, 16'h0020));
        act(6);
        dial_pointer <= 16'($random(seed)) | 16'h0001;
        q.push_back(ex(1, 0, 0, 16'h0022));
        act(5);
        chk(dials, 1);
        q.push_back(ex(0, 0, 0, 16'h0020));
        act(6);
        options_word <= 16'h0010;
        act(1);
        chk(status_word, 16'h0020);
        options_word <= 16'h0000;
        q.push_back(ex(1, 0, 0, 16'h8020));
        hook_req <= 1'b1;
        hold(25);
        chk(dials, 2);
        q.push_back(ex(0, 0, 0, 16'h0020));
        hook_req <= 1'b0;
        hold(25);
        // continuation holds the line after the input drops
        q.push_back(ex(1, 0, 0, 16'h8020));
        hook_req <= 1'b1;
        dial_continue <= 1'b1;
        hold(25);
        q.push_back(ex(1, 0, 0, 16'h0020));
        hook_req <= 1'b0;
        hold(25);
        chk(oh, 1'b1);
        carrier_detect <= 1'b1;
        hold(4);
        chk(oh, 1'b0);
        carrier_detect <= 1'b0;
        dial_continue <= 1'b0;
        hold(2);
        for (i = 0; i < 4; i++) begin
            {command_word[6], rts} <= 2'(i ^ ($random(seed) & 0));
            hold(4);
            chk(talk, i != 0);
        end
        command_word <= 16'h0008;
        hold(4);
        chk({md, error_word}, 17'h00008);
        command_word <= 16'hc018;
        hold(4);
        chk({md, tw, fw, oh}, 4'b1101);
        command_word <= 16'h0018;
        hold(4);
        chk({md, tw, fw}, 3'b000);
        snap = carriers;
        command_word <= 16'h4000;
        hold(4);
        chk({fw, tw, 2'(carriers - snap)}, 4'b1001);
        // this end originates, the far end answers
        carrier_detect <= 1'b1;
        hold(4);
        carrier_detect <= 1'b0;
        hold(4);
        chk(carriers - snap, 2);
        command_word <= 16'h0080;
        // zero pointer: keep-alive edges must not dial
        dial_pointer <= 16'h0000;
        watch = 1'b0;
        keep_alive <= 1'b1;
        snap = dials;
        hold(80);
        chk(dials - snap, 0);
        keep_alive <= 1'b0;
        for (i = 0; i < 100 && dials == snap; i++) begin
            hold(1);
        end
        if (dials == snap) begin
            bad_count++;
            tally_and_finish();
        end
        hold(2);
        chk({oh, 2'(dials - snap)}, 3'b101);
        command_word <= 16'h0000;
        do_reset();
        watch = 1'b1;
        options_word <= 16'h0008;
        q.push_back(ex(1, 0, 0, 16'h8020));
        hook_req <= 1'b1;
        hold(25);
        q.push_back(ex(1, 0, 0, 16'h0020));
        hook_req <= 1'b0;
        hold(25);
        chk(q.size(), 0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
